// ### design/cnm_nmt_regs.svh
// Constants for the node identity and NMT command handler
// Assumes a plain register port with byte addresses, one word each
// Functional notes
// - First identity set adopts the ID, starts frames, initialises all COB-IDs.
// - Identity set is a command error in Operational or Stopped.
// - Later positive ID changes only the ID; negated ID also reinitialises COB-IDs.
// - ID zero takes low 7 serial bits; 1 to 127 used directly.
// - Serial-derived ID of zero is a command error, reserved for broadcast.
// - Local request 1 Operational, 2 Stopped, 128 Pre-Operational, 130 reset then Pre-Op.
// - Local request accepts only its four codes, distinct from state codes.
// - State reported as 127 Pre-Operational, 5 Operational, 4 Stopped.
// - Pre-Operational allows NMT, SDO and dictionary access, no PDO.
// - Operational allows NMT, SDO and PDO traffic.
// - Stopped allows NMT only, no SDO or PDO.
// - Communication reset restores default COB-IDs then enters Pre-Operational.
// - Remote node reset code 129 fully resets targeted nodes.
// - Remote target 0 addresses all nodes, 1 to 127 one node.
// - Free transmit buffer: remote frame queued, only Zero flag set.
// - Pending earlier transmission: nothing sent, only Negative flag set.
// - Remote request accepts only codes 1, 2, 128, 129 and 130.
// - Writes to state-dependent dictionary objects only in Pre-Operational.
`ifndef CNM_NMT_REGS_SVH
`define CNM_NMT_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define CNM_ID_SET_OFS    8'h00
`define CNM_LOCAL_OFS     8'h04
`define CNM_REMOTE_OFS    8'h08
`define CNM_STATUS_OFS    8'h0C
`define CNM_SERIAL_OFS    8'h10

// ****************************************
// Status field positions
// ****************************************
`define CNM_STS_CODE_LSB  0
`define CNM_STS_ID_LSB    8
`define CNM_STS_CFG_BIT   15
`define CNM_STS_ERR_BIT   16
`define CNM_STS_ZERO_BIT  17
`define CNM_STS_NEG_BIT   18
`define CNM_STS_PEND_BIT  19
`define CNM_STS_CANEN_BIT 20
`define CNM_REM_TGT_LSB   16

// ****************************************
// Request and state codes
// ****************************************
`define CNM_REQ_OP        16'h0001
`define CNM_REQ_STOP      16'h0002
`define CNM_REQ_PRE       16'h0080
`define CNM_REQ_RST_NODE  16'h0081
`define CNM_REQ_RST_COMM  16'h0082
`define CNM_CODE_INIT     8'h00
`define CNM_CODE_PRE      8'h7F
`define CNM_CODE_OP       8'h05
`define CNM_CODE_STOP     8'h04
`define CNM_ID_MAX        16'h007F
`define CNM_ID_NEG_MIN    16'hFF81
`define CNM_TGT_MAX       16'h007F

`endif

// ### design/cnm_pkg.sv
// Types shared by the node identity and NMT command handler
// Assumes constants come from cnm_nmt_regs.svh
package cnm_pkg;

   // NMT states, init is before CAN is configured
   typedef enum logic [1:0] {ST_INIT, ST_PRE, ST_OP, ST_STOP} cnm_nmt_t;

   // Whole state of the command handler
   typedef struct packed {
      cnm_nmt_t    st;
      logic [7:0]  code;
      logic [6:0]  node_id;
      logic        configured;
      logic        can_en;
      logic        cobid_init;
      logic        cmd_err;
      logic        zero;
      logic        neg;
      logic        tx_valid;
      logic [7:0]  tx_cs;
      logic [6:0]  tx_node;
      logic [31:0] rdata;
      logic        allow_nmt;
      logic        allow_sdo;
      logic        allow_pdo;
      logic        dict_wr;
   } cnm_state_t;

endpackage

// ### design/cnm_sync.sv
// Two-stage synchroniser for a bus of pin levels
// Assumes the levels change slowly compared with clk_i
`timescale 1ns/1ps
module cnm_sync #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Levels
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } cnm_sync_t;

   cnm_sync_t r;
   cnm_sync_t next_r;

   // First stage feeds only the second
   always_comb begin
      next_r.s1 = d_i;
      next_r.s2 = r.s1;
   end

   // Register both stages
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign q_o = r.s2;
endmodule

// ### design/cnm_perm.sv
// Traffic permissions for each NMT state
// Assumes the caller registers the outputs
`timescale 1ns/1ps
module cnm_perm import cnm_pkg::*; (
   // State in
   input  wire cnm_nmt_t st_i,
   // Permissions out
   output logic          nmt_o,
   output logic          sdo_o,
   output logic          pdo_o,
   output logic          dict_o
);
   // Decode permissions from state
   always_comb begin
      nmt_o  = 1'b0;
      sdo_o  = 1'b0;
      pdo_o  = 1'b0;
      dict_o = 1'b0;
      case (st_i)
         ST_PRE: begin
            nmt_o  = 1'b1;
            sdo_o  = 1'b1;
            dict_o = 1'b1;
         end
         ST_OP: begin
            nmt_o = 1'b1;
            sdo_o = 1'b1;
            pdo_o = 1'b1;
         end
         ST_STOP: begin
            nmt_o = 1'b1;
         end
         default: begin
            nmt_o = 1'b0;
         end
      endcase
   end
endmodule

// ### design/cnm_nmt_ctrl.sv
// Node identity and NMT command handler, top level
// Assumes a register port on clk_i and a CAN transmitter
// that pulses nmt_tx_done_i when a queued NMT frame has left
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "cnm_nmt_regs.svh"
module cnm_nmt_ctrl import cnm_pkg::*; (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Register port
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   // Serial identifier pins
   input  wire logic [15:0] serial_id_i,
   // NMT transmit buffer
   input  wire logic        nmt_tx_done_i,
   output logic             nmt_tx_valid_o,
   output logic      [7:0]  nmt_tx_cs_o,
   output logic      [6:0]  nmt_tx_node_o,
   // Node identity
   output logic      [6:0]  node_id_o,
   output logic             can_en_o,
   output logic             cobid_init_o,
   // NMT state and traffic gates
   output logic      [7:0]  nmt_state_o,
   output logic             allow_nmt_o,
   output logic             allow_sdo_o,
   output logic             allow_pdo_o,
   output logic             dict_wr_en_o
);

   // ****************************************
   // Declarations
   // ****************************************
   cnm_state_t  r;
   cnm_state_t  next_r;
   logic [15:0] ser_s;
   logic        p_nmt;
   logic        p_sdo;
   logic        p_pdo;
   logic        p_dict;
   logic [15:0] id_val;
   logic [15:0] id_mag;
   logic [15:0] req;
   logic [15:0] tgt;
   logic        wr_id;
   logic        wr_loc;
   logic        wr_rem;
   logic        req_ok;

   // ****************************************
   // Submodules
   // ****************************************

   // Serial identifier pins into clock domain
   cnm_sync #(
      .W (16)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (serial_id_i),
      .q_o   (ser_s)
   );

   // Permissions for the present state
   cnm_perm u_perm (
      .st_i   (r.st),
      .nmt_o  (p_nmt),
      .sdo_o  (p_sdo),
      .pdo_o  (p_pdo),
      .dict_o (p_dict)
   );

   // ****************************************
   // Command decode helpers
   // ****************************************
   always_comb begin
      id_val = wdata_i[15:0];
      id_mag = 16'h0000 - wdata_i[15:0];
      req    = wdata_i[15:0];
      tgt    = wdata_i[31:16];
      wr_id  = wr_i && (addr_i == `CNM_ID_SET_OFS);
      wr_loc = wr_i && (addr_i == `CNM_LOCAL_OFS);
      wr_rem = wr_i && (addr_i == `CNM_REMOTE_OFS);
      req_ok = (req == `CNM_REQ_OP) || (req == `CNM_REQ_STOP) ||
               (req == `CNM_REQ_PRE) || (req == `CNM_REQ_RST_NODE) ||
               (req == `CNM_REQ_RST_COMM);
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_r            = r;
      next_r.cobid_init = 1'b0;
      next_r.rdata      = 32'h0000_0000;

      // Register reads, unmapped reads as zero
      if (rd_i) begin
         case (addr_i)
            `CNM_STATUS_OFS: begin
               next_r.rdata[`CNM_STS_CODE_LSB +: 8] = r.code;
               next_r.rdata[`CNM_STS_ID_LSB +: 7]   = r.node_id;
               next_r.rdata[`CNM_STS_CFG_BIT]       = r.configured;
               next_r.rdata[`CNM_STS_ERR_BIT]       = r.cmd_err;
               next_r.rdata[`CNM_STS_ZERO_BIT]      = r.zero;
               next_r.rdata[`CNM_STS_NEG_BIT]       = r.neg;
               next_r.rdata[`CNM_STS_PEND_BIT]      = r.tx_valid;
               next_r.rdata[`CNM_STS_CANEN_BIT]     = r.can_en;
            end
            `CNM_REMOTE_OFS: begin
               next_r.rdata[7:0]                     = r.tx_cs;
               next_r.rdata[`CNM_REM_TGT_LSB +: 7]   = r.tx_node;
            end
            `CNM_SERIAL_OFS: begin
               next_r.rdata[15:0] = ser_s;
            end
            default: begin
               next_r.rdata = 32'h0000_0000;
            end
         endcase
      end

      // Transmitter has sent the queued frame
      if (r.tx_valid && nmt_tx_done_i) begin
         next_r.tx_valid = 1'b0;
      end

      // Any command clears the result flags
      if (wr_id || wr_loc || wr_rem) begin
         next_r.cmd_err = 1'b0;
         next_r.zero    = 1'b0;
         next_r.neg     = 1'b0;
      end

      // Identity set command
      if (wr_id) begin
         if ((r.st == ST_OP) || (r.st == ST_STOP)) begin
            next_r.cmd_err = 1'b1;
         end else if (id_val == 16'h0000) begin
            if (ser_s[6:0] == 7'h00) begin
               next_r.cmd_err = 1'b1;
            end else begin
               next_r.node_id    = ser_s[6:0];
               next_r.cobid_init = !r.configured;
               next_r.configured = 1'b1;
            end
         end else if (id_val <= `CNM_ID_MAX) begin
            next_r.node_id    = id_val[6:0];
            next_r.cobid_init = !r.configured;
            next_r.configured = 1'b1;
         end else if (id_val >= `CNM_ID_NEG_MIN) begin
            next_r.node_id    = id_mag[6:0];
            next_r.cobid_init = 1'b1;
            next_r.configured = 1'b1;
         end else begin
            next_r.cmd_err = 1'b1;
         end
         if (!next_r.cmd_err) begin
            next_r.can_en = 1'b1;
            next_r.st     = ST_PRE;
         end
      end

      // Local transition command, needs CAN running
      if (wr_loc) begin
         if (r.st == ST_INIT) begin
            next_r.cmd_err = 1'b1;
         end else begin
            case (req)
               `CNM_REQ_OP: begin
                  next_r.st = ST_OP;
               end
               `CNM_REQ_STOP: begin
                  next_r.st = ST_STOP;
               end
               `CNM_REQ_PRE: begin
                  next_r.st = ST_PRE;
               end
               `CNM_REQ_RST_COMM: begin
                  next_r.cobid_init = 1'b1;
                  next_r.st         = ST_PRE;
               end
               default: begin
                  next_r.cmd_err = 1'b1;
               end
            endcase
         end
      end

      // Remote transition command
      if (wr_rem) begin
         if (!req_ok || (tgt > `CNM_TGT_MAX) || (r.st == ST_INIT)) begin
            next_r.cmd_err = 1'b1;
         end else if (r.tx_valid) begin
            next_r.neg = 1'b1;
         end else begin
            next_r.zero     = 1'b1;
            next_r.tx_valid = 1'b1;
            next_r.tx_cs    = req[7:0];
            next_r.tx_node  = tgt[6:0];
         end
      end

      case (next_r.st)
         ST_PRE: begin
            next_r.code = `CNM_CODE_PRE;
         end
         ST_OP: begin
            next_r.code = `CNM_CODE_OP;
         end
         ST_STOP: begin
            next_r.code = `CNM_CODE_STOP;
         end
         default: begin
            next_r.code = `CNM_CODE_INIT;
         end
      endcase

      // Registered traffic gates
      next_r.allow_nmt = p_nmt;
      next_r.allow_sdo = p_sdo;
      next_r.allow_pdo = p_pdo;
      next_r.dict_wr   = p_dict;
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r    <= '0;
         r.st <= ST_INIT;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from the state register
   assign rdata_o        = r.rdata;
   assign nmt_tx_valid_o = r.tx_valid;
   assign nmt_tx_cs_o    = r.tx_cs;
   assign nmt_tx_node_o  = r.tx_node;
   assign node_id_o      = r.node_id;
   assign can_en_o       = r.can_en;
   assign cobid_init_o   = r.cobid_init;
   assign nmt_state_o    = r.code;
   assign allow_nmt_o    = r.allow_nmt;
   assign allow_sdo_o    = r.allow_sdo;
   assign allow_pdo_o    = r.allow_pdo;
   assign dict_wr_en_o   = r.dict_wr;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Command writes: local with a given code, identity set in Init or Pre-Operational
   sequence s_loc(logic [15:0] c);
      wr_loc && (req == c) && (r.st != ST_INIT);
   endsequence

   sequence s_id_ok;
      wr_id && ((r.st == ST_INIT) || (r.st == ST_PRE));
   endsequence

   AST_ID_FIRST: assert property ((s_id_ok and (!r.configured &&
      ((id_val != 16'h0000) || (ser_s[6:0] != 7'h00)) &&
      ((id_val <= `CNM_ID_MAX) || (id_val >= `CNM_ID_NEG_MIN))))
      |=> cobid_init_o && can_en_o && (nmt_state_o == `CNM_CODE_PRE))
      else $error("first identity set did not start CAN");

   AST_ID_BUSY: assert property (wr_id && ((r.st == ST_OP) || (r.st == ST_STOP))
      |=> r.cmd_err && $stable(node_id_o))
      else $error("identity set accepted while running");

   AST_ID_NEG: assert property ((s_id_ok and (id_val >= `CNM_ID_NEG_MIN))
      |=> cobid_init_o && (node_id_o == $past(id_mag[6:0])))
      else $error("negated identity did not reinitialise");

   AST_ID_POS: assert property ((s_id_ok and (r.configured && (id_val != 16'h0000) &&
      (id_val <= `CNM_ID_MAX))) |=> !cobid_init_o && (node_id_o == $past(id_val[6:0])))
      else $error("positive identity misbehaved");

   AST_ID_SER: assert property ((s_id_ok and ((id_val == 16'h0000) && (ser_s[6:0] != 7'h00)))
      |=> node_id_o == $past(ser_s[6:0]))
      else $error("serial identity not taken");

   AST_ID_BCAST: assert property ((s_id_ok and ((id_val == 16'h0000) && (ser_s[6:0] == 7'h00)))
      |=> r.cmd_err && $stable(node_id_o))
      else $error("broadcast identity not refused");

   AST_LOC_OP: assert property (s_loc(`CNM_REQ_OP) |=> nmt_state_o == `CNM_CODE_OP
      ##1 allow_pdo_o && allow_sdo_o)
      else $error("local operational request failed");

   AST_LOC_STOP: assert property (s_loc(`CNM_REQ_STOP) |=> nmt_state_o == `CNM_CODE_STOP
      ##1 allow_nmt_o && !allow_sdo_o && !allow_pdo_o)
      else $error("stopped state gates wrong");

   AST_LOC_RST: assert property (s_loc(`CNM_REQ_RST_COMM)
      |=> cobid_init_o && (nmt_state_o == `CNM_CODE_PRE) ##1 !allow_pdo_o && dict_wr_en_o)
      else $error("communication reset failed");

   AST_LOC_BAD: assert property (wr_loc && !req_ok
      |=> r.cmd_err && $stable(nmt_state_o))
      else $error("undefined local code not refused");

   AST_REM_Q: assert property (wr_rem && req_ok && (tgt <= `CNM_TGT_MAX) &&
      (r.st != ST_INIT) && !r.tx_valid
      |=> nmt_tx_valid_o && r.zero && !r.neg && (nmt_tx_node_o == $past(tgt[6:0])))
      else $error("remote frame not queued");

   AST_REM_BUSY: assert property (wr_rem && req_ok && (tgt <= `CNM_TGT_MAX) &&
      (r.st != ST_INIT) && r.tx_valid |=> r.neg && !r.zero && $stable(nmt_tx_cs_o))
      else $error("busy buffer not reported");

   AST_REM_BAD: assert property (wr_rem && !req_ok
      |=> r.cmd_err && !r.zero && !r.neg)
      else $error("undefined remote code not refused");

   AST_DICT: assert property (dict_wr_en_o |-> $past(r.st) == ST_PRE)
      else $error("dictionary write open outside pre-op");

endmodule

// ### dv/cnm_tx_model.sv
// Model of the CAN transmitter behind the NMT transmit buffer
// Assumes the handler's clock; sends a queued frame after a short or long delay
`timescale 1ns/1ps
module cnm_tx_model (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Buffer handshake
   input  wire logic valid_i,
   input  wire logic slow_i,
   output logic      done_o
);
   int cnt;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt    <= 0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (!valid_i || done_o) begin
            cnt <= 0;
         end else if (cnt == (slow_i ? 30 : 3)) begin
            done_o <= 1'b1; // One-cycle sent pulse
            cnt    <= 0;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule

// ### dv/testbench.sv
// Self-checking bench for the node identity and NMT command handler
// Assumes the register port and status layout of cnm_nmt_regs.svh
`timescale 1ns/1ps
`include "cnm_nmt_regs.svh"
module testbench;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic [15:0] serial_id_i = 16'h0000;
   logic        slow = 1'b0;
   logic        cfg = 1'b0;
   logic        done;
   logic [31:0] rdata_o;
   logic        nmt_tx_valid_o;
   logic [7:0]  nmt_tx_cs_o;
   logic [6:0]  nmt_tx_node_o;
   logic [6:0]  node_id_o;
   logic        can_en_o;
   logic        cobid_init_o;
   logic [7:0]  nmt_state_o;
   logic        allow_nmt_o;
   logic        allow_sdo_o;
   logic        allow_pdo_o;
   logic        dict_wr_en_o;
   int          mismatches = 0;
   int          comparisons = 0;
   // Identity values with expected id, pulse and error
   logic [15:0] idv [5] = '{16'h0005, 16'hFFFB, 16'hFF81, 16'h0080, 16'h007F};
   logic [6:0]  ide [5] = '{7'h05, 7'h05, 7'h7F, 7'h7F, 7'h7F};
   logic        idc [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
   logic        idr [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
   // Local requests with expected state, gates, pulse and error
   logic [15:0] lc [8] = '{16'h1, 16'h2, 16'h80, 16'h1, 16'h82, 16'h3, 16'h81, 16'h5};
   logic [7:0]  ls [8] = '{8'h05, 8'h04, 8'h7F, 8'h05, 8'h7F, 8'h7F, 8'h7F, 8'h7F};
   logic [3:0]  lp [8] = '{4'hE, 4'h8, 4'hD, 4'hE, 4'hD, 4'hD, 4'hD, 4'hD};
   logic        lk [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
   logic        le [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
   // Remote requests and targets
   logic [15:0] rc [5] = '{16'h1, 16'h2, 16'h80, 16'h81, 16'h82};
   logic [15:0] rt [5] = '{16'h0, 16'h7F, 16'h5, 16'h0, 16'h1};

   // Clock
   always #4 clk_i = ~clk_i;

   cnm_nmt_ctrl dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .serial_id_i(serial_id_i), .nmt_tx_done_i(done),
      .nmt_tx_valid_o(nmt_tx_valid_o), .nmt_tx_cs_o(nmt_tx_cs_o), .nmt_tx_node_o(nmt_tx_node_o),
      .node_id_o(node_id_o), .can_en_o(can_en_o), .cobid_init_o(cobid_init_o),
      .nmt_state_o(nmt_state_o), .allow_nmt_o(allow_nmt_o), .allow_sdo_o(allow_sdo_o),
      .allow_pdo_o(allow_pdo_o), .dict_wr_en_o(dict_wr_en_o)
   );

   cnm_tx_model tx_u (
      .clk_i(clk_i), .rst_i(rst_i), .valid_i(nmt_tx_valid_o), .slow_i(slow), .done_o(done)
   );

   // ****************************************
   // Access and compare tasks
   // ****************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      @(posedge clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      q = rdata_o;
   endtask

   // Status word: flags are negative, zero, error
   task automatic sts(input logic [7:0] c, input logic [6:0] id, input logic [2:0] f, input logic p);
      logic [31:0] q;
      rd(`CNM_STATUS_OFS, q);
      chk(q, {11'h0, cfg, p, f, cfg, id, c});
   endtask

   task automatic idle_wait;
      int n;
      n = 0;
      while (nmt_tx_valid_o !== 1'b0 && n < 100) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      chk(32'(nmt_tx_valid_o), 32'h0);
   endtask

   task automatic end_of_test;
      if (mismatches == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      #100000;
      mismatches++;
      end_of_test();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic [31:0] q;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      wr(`CNM_LOCAL_OFS, 32'h1);
      sts(8'h00, 7'h00, 3'b001, 1'b0);
      @(posedge clk_i);
      serial_id_i <= 16'h0080;
      repeat (3) @(posedge clk_i);
      wr(`CNM_ID_SET_OFS, 32'h0);
      chk(32'(can_en_o), 32'h0);
      sts(8'h00, 7'h00, 3'b001, 1'b0);
      @(posedge clk_i);
      serial_id_i <= 16'h01A3;
      repeat (3) @(posedge clk_i);
      wr(`CNM_ID_SET_OFS, 32'h0);
      chk(32'(cobid_init_o), 32'h1);
      chk(32'(node_id_o), 32'h23);
      chk(32'(can_en_o), 32'h1);
      cfg = 1'b1;
      sts(8'h7F, 7'h23, 3'b000, 1'b0);
      for (int i = 0; i < 5; i++) begin
         wr(`CNM_ID_SET_OFS, {16'h0, idv[i]});
         chk(32'(cobid_init_o), 32'(idc[i]));
         chk(32'(node_id_o), 32'(ide[i]));
         sts(8'h7F, ide[i], {2'b00, idr[i]}, 1'b0);
      end
      chk({28'h0, allow_nmt_o, allow_sdo_o, allow_pdo_o, dict_wr_en_o}, 32'hD);
      for (int i = 0; i < 8; i++) begin
         wr(`CNM_LOCAL_OFS, {16'h0, lc[i]});
         chk(32'(nmt_state_o), 32'(ls[i]));
         chk(32'(cobid_init_o), 32'(lk[i]));
         @(posedge clk_i);
         #1;
         chk({28'h0, allow_nmt_o, allow_sdo_o, allow_pdo_o, dict_wr_en_o}, 32'(lp[i]));
         sts(ls[i], 7'h7F, {2'b00, le[i]}, 1'b0);
         if (i < 2) begin
            wr(`CNM_ID_SET_OFS, 32'h9);
            sts(ls[i], 7'h7F, 3'b001, 1'b0);
         end
      end
      @(posedge clk_i);
      slow <= 1'b1;
      wr(`CNM_REMOTE_OFS, 32'h0010_0001);
      chk({nmt_tx_valid_o, 16'h0, nmt_tx_node_o, nmt_tx_cs_o}, 32'h8000_1001);
      sts(8'h7F, 7'h7F, 3'b010, 1'b1);
      wr(`CNM_REMOTE_OFS, 32'h0020_0002);
      sts(8'h7F, 7'h7F, 3'b100, 1'b1);
      chk({nmt_tx_valid_o, 16'h0, nmt_tx_node_o, nmt_tx_cs_o}, 32'h8000_1001);
      idle_wait();
      @(posedge clk_i);
      slow <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         wr(`CNM_REMOTE_OFS, {rt[i], rc[i]});
         chk({nmt_tx_valid_o, 16'h0, nmt_tx_node_o, nmt_tx_cs_o},
             {1'b1, 16'h0, rt[i][6:0], rc[i][7:0]});
         chk(32'(nmt_state_o), 32'h7F);
         idle_wait();
      end
      rd(`CNM_REMOTE_OFS, q);
      chk(q, 32'h0001_0082);
      rd(`CNM_SERIAL_OFS, q);
      chk(q, 32'h0000_01A3);
      wr(`CNM_REMOTE_OFS, 32'h0001_0003);
      sts(8'h7F, 7'h7F, 3'b001, 1'b0);
      wr(`CNM_REMOTE_OFS, 32'h0080_0001);
      sts(8'h7F, 7'h7F, 3'b001, 1'b0);
      rd(8'h20, q);
      chk(q, 32'h0);
      end_of_test();
   end
endmodule
